// >>> dtc_timer.sv
// Dual timer/counter with external interrupt detection.
// Assumes the register port master of the core clock; pins are asynchronous.
`timescale 1ns/1ps
module dtc_timer
   import dtc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Pins
   input wire logic external_interrupt_pin_0,
   input wire logic external_interrupt_pin_1,
   input wire logic count_pin_0,
   input wire logic count_pin_1,
   // Vector acknowledges from the interrupt controller
   input wire logic timer0_vector_ack,
   input wire logic timer1_vector_ack,
   input wire logic ext_external_interrupt_pin_0_vector_ack,
   input wire logic ext_external_interrupt_pin_1_vector_ack,
   // Interrupt requests
   output logic timer0_irq,
   output logic timer1_irq,
   output logic ext_external_interrupt_pin_0_irq,
   output logic ext_external_interrupt_pin_1_irq,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_d;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1 <= 4'hf;
         pin_s2 <= 4'hf;
         pin_d <= 4'hf;
      end else begin
         pin_s1 <= {count_pin_1, count_pin_0, external_interrupt_pin_1,
                    external_interrupt_pin_0};
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end
   logic xpin0_lvl;
   logic xpin1_lvl;
   logic xpin0_fall;
   logic xpin1_fall;
   logic t0_fall;
   logic t1_fall;
   assign xpin0_lvl = pin_s2[0];
   assign xpin1_lvl = pin_s2[1];
   assign xpin0_fall = pin_d[0] & ~pin_s2[0];
   assign xpin1_fall = pin_d[1] & ~pin_s2[1];
   assign t0_fall = pin_d[2] & ~pin_s2[2];
   assign t1_fall = pin_d[3] & ~pin_s2[3];

   ////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] tctrl;
   logic [7:0] tmode;
   logic [7:0] ckdiv;
   logic [7:0] t0_low;
   logic [7:0] t0_high;
   logic [7:0] t1_low;
   logic [7:0] t1_high;
   logic [3:0] imask;
   logic [3:0] istat;
   logic [7:0] next_tctrl;
   logic [7:0] next_tmode;
   logic [7:0] next_ckdiv;
   logic [7:0] next_t0_low;
   logic [7:0] next_t0_high;
   logic [7:0] next_t1_low;
   logic [7:0] next_t1_high;
   logic [3:0] next_imask;
   logic [3:0] next_istat;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////
   // Divided clock ticks
   logic tick0;
   logic tick1;
   dtc_tick u_tick0 (
      .core_clk(core_clk),
      .rst(rst),
      .fast_sel(ckdiv[B_FAST0]),
      .tick(tick0)
   );
   dtc_tick u_tick1 (
      .core_clk(core_clk),
      .rst(rst),
      .fast_sel(ckdiv[B_FAST1]),
      .tick(tick1)
   );

   ////////////////////////////////////////////////////////////////////
   // Count enables
   logic [3:0] cfg0;
   logic [3:0] cfg1;
   logic en0;
   logic en1;
   logic inc0;
   logic inc1;
   logic inc_t0_high;
   assign cfg0 = tmode[3:0];
   assign cfg1 = tmode[7:4];
   // Pin qualify gates run with the interrupt pin
   assign en0 = tctrl[B_RUN0] & (~cfg0[B_GATE] | xpin0_lvl); // [RULE2] [RULE5] [RULE6]
   assign en1 = tctrl[B_RUN1] & (~cfg1[B_GATE] | xpin1_lvl); // [RULE2] [RULE5] [RULE6]
   // Source select: divided clock or count pin edge
   assign inc0 = en0 & (cfg0[B_CT] ? t0_fall : tick0); // [RULE7]
   assign inc1 = en1 & (cfg1[B_CT] ? t1_fall : tick1) &
                 (cfg1[1:0] != MODE_SPLIT); // [RULE12]
   // Split high byte: timer 1 run bit, internal clock only
   assign inc_t0_high = tctrl[B_RUN1] & tick0; // [RULE11]

   logic addr_ok;
   always_comb begin
      case (reg_addr)
         ADDR_TCTRL, ADDR_TMODE, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH, ADDR_T1_HIGH,
         ADDR_CKDIV, ADDR_ISTAT, ADDR_IMASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Timer next-state and register writes
   logic ovf0;
   logic ovf1;
   logic ovf_t0_high;
   logic wr_t0_low;
   logic wr_t0_high;
   logic wr_t1_low;
   logic wr_t1_high;
   assign wr_t0_low = reg_wr & (reg_addr == ADDR_T0_LOW);
   assign wr_t0_high = reg_wr & (reg_addr == ADDR_T0_HIGH);
   assign wr_t1_low = reg_wr & (reg_addr == ADDR_T1_LOW);
   assign wr_t1_high = reg_wr & (reg_addr == ADDR_T1_HIGH);

   // One timer step: low/high bytes by mode, returns overflow
   function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      case (mode)
         MODE_13: begin
            if (lo[4:0] == PRESC_MAX) begin // [RULE8]
               r[4:0] = 5'h00;
               r[16:8] = {1'b0, hi} + 9'h001;
            end else begin
               r[4:0] = lo[4:0] + 5'h01;
            end
         end
         MODE_16: r = {1'b0, hi, lo} + 17'h00001; // [RULE9]
         MODE_AR: begin
            if (lo == 8'hff) begin // [RULE10]
               r = {1'b1, hi, hi};
            end else begin
               r[7:0] = lo + 8'h01;
            end
         end
         default: r[8:0] = {1'b0, lo} + 9'h001; // Split low byte
      endcase
      if (mode == MODE_SPLIT) begin
         r[16] = r[8];
         r[15:8] = hi;
      end
      return r;
   endfunction : step

   logic [16:0] s0;
   logic [16:0] s1;
   logic [8:0] sh0;
   always_comb begin
      s0 = step(cfg0[1:0], t0_low, t0_high);
      s1 = step(cfg1[1:0], t1_low, t1_high);
      sh0 = {1'b0, t0_high} + 9'h001;
      ovf0 = inc0 & s0[16];
      ovf1 = inc1 & s1[16];
      ovf_t0_high = (cfg0[1:0] == MODE_SPLIT) & inc_t0_high & sh0[8];
      next_t0_low = inc0 ? s0[7:0] : t0_low;
      next_t0_high = t0_high;
      if (cfg0[1:0] == MODE_SPLIT) begin
         if (inc_t0_high) begin
            next_t0_high = sh0[7:0]; // [RULE11]
         end
      end else if (inc0) begin
         next_t0_high = s0[15:8];
      end
      next_t1_low = inc1 ? s1[7:0] : t1_low;
      next_t1_high = inc1 ? s1[15:8] : t1_high;
      // Software writes replace the running count
      if (wr_t0_low) next_t0_low = reg_wdata; // [RULE16]
      if (wr_t0_high) next_t0_high = reg_wdata; // [RULE16]
      if (wr_t1_low) next_t1_low = reg_wdata; // [RULE16]
      if (wr_t1_high) next_t1_high = reg_wdata; // [RULE16]
   end

   ////////////////////////////////////////////////////////////////////
   // Control, flags, interrupt status
   logic set_ovf0;
   logic set_ovf1;
   logic set_xdet0;
   logic set_xdet1;
   // Split mode: timer 0 high byte owns timer 1's flag
   assign set_ovf0 = ovf0; // [RULE1]
   assign set_ovf1 = (cfg0[1:0] == MODE_SPLIT) ? ovf_t0_high : ovf1; // [RULE1] [RULE11]
   assign set_xdet0 = tctrl[B_XTYPE0] ? xpin0_fall : ~xpin0_lvl; // [RULE3] [RULE4]
   assign set_xdet1 = tctrl[B_XTYPE1] ? xpin1_fall : ~xpin1_lvl; // [RULE3] [RULE4]

   always_comb begin
      next_tctrl = tctrl;
      next_tmode = tmode;
      next_ckdiv = ckdiv;
      next_imask = imask;
      next_istat = istat;
      if (reg_wr && reg_addr == ADDR_TCTRL) next_tctrl = reg_wdata; // [RULE14] [RULE2]
      if (reg_wr && reg_addr == ADDR_TMODE) next_tmode = reg_wdata; // [RULE15]
      if (reg_wr && reg_addr == ADDR_CKDIV) next_ckdiv = reg_wdata; // [RULE13]
      if (reg_wr && reg_addr == ADDR_IMASK) next_imask = reg_wdata[3:0];
      if (reg_wr && reg_addr == ADDR_ISTAT) next_istat = istat & ~reg_wdata[3:0];
      // Acknowledge clears, hardware sets win
      if (timer0_vector_ack) next_tctrl[B_OVF0] = 1'b0; // [RULE1]
      if (timer1_vector_ack) next_tctrl[B_OVF1] = 1'b0; // [RULE1]
      if (ext_external_interrupt_pin_0_vector_ack && tctrl[B_XTYPE0]) next_tctrl[B_XDET0] = 1'b0; // [RULE3]
      if (ext_external_interrupt_pin_1_vector_ack && tctrl[B_XTYPE1]) next_tctrl[B_XDET1] = 1'b0; // [RULE3]
      if (!tctrl[B_XTYPE0]) next_tctrl[B_XDET0] = ~xpin0_lvl; // [RULE3]
      if (!tctrl[B_XTYPE1]) next_tctrl[B_XDET1] = ~xpin1_lvl; // [RULE3]
      if (set_ovf0) next_tctrl[B_OVF0] = 1'b1; // [RULE1]
      if (set_ovf1) next_tctrl[B_OVF1] = 1'b1; // [RULE1]
      if (set_xdet0) next_tctrl[B_XDET0] = 1'b1; // [RULE3]
      if (set_xdet1) next_tctrl[B_XDET1] = 1'b1; // [RULE3]
      next_istat = next_istat | {set_xdet1, set_xdet0, set_ovf1, set_ovf0};
   end

   ////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_TCTRL: next_rdata = tctrl;
            ADDR_TMODE: next_rdata = tmode;
            ADDR_T0_LOW: next_rdata = t0_low; // [RULE16]
            ADDR_T1_LOW: next_rdata = t1_low;
            ADDR_T0_HIGH: next_rdata = t0_high;
            ADDR_T1_HIGH: next_rdata = t1_high;
            ADDR_CKDIV: next_rdata = ckdiv;
            ADDR_ISTAT: next_rdata = {4'h0, istat};
            ADDR_IMASK: next_rdata = {4'h0, imask};
            default: next_rdata = addr_ok ? 8'h00 : 8'hff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tctrl <= 8'h00;
         tmode <= 8'h00;
         ckdiv <= CKDIV_RESET;
         t0_low <= 8'h00;
         t0_high <= 8'h00;
         t1_low <= 8'h00;
         t1_high <= 8'h00;
         imask <= 4'h0;
         istat <= 4'h0;
         reg_rdata <= 8'h00;
      end else begin
         tctrl <= next_tctrl;
         tmode <= next_tmode;
         ckdiv <= next_ckdiv;
         t0_low <= next_t0_low;
         t0_high <= next_t0_high;
         t1_low <= next_t1_low;
         t1_high <= next_t1_high;
         imask <= next_imask;
         istat <= next_istat;
         reg_rdata <= next_rdata;
      end
   end

   assign timer0_irq = tctrl[B_OVF0];
   assign timer1_irq = tctrl[B_OVF1];
   assign ext_external_interrupt_pin_0_irq = tctrl[B_XDET0];
   assign ext_external_interrupt_pin_1_irq = tctrl[B_XDET1];
   assign irq = |(istat & imask);

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
      set_ovf0 |=> tctrl[B_OVF0]) // [RULE1]
      else $error("timer 0 overflow flag not set");
   a_run_holds: assert property (@(posedge core_clk) disable iff (rst)
      (!tctrl[B_RUN0] && !wr_t0_low && cfg0[1:0] != MODE_SPLIT) |=> $stable(t0_low)) // [RULE2]
      else $error("timer 0 moved while stopped");
   a_level_follow: assert property (@(posedge core_clk) disable iff (rst)
      (!tctrl[B_XTYPE0] && !xpin0_lvl && !(reg_wr && reg_addr == ADDR_TCTRL))
      |=> tctrl[B_XDET0]) // [RULE3]
      else $error("level detect flag missing");
   a_edge_detect: assert property (@(posedge core_clk) disable iff (rst)
      (tctrl[B_XTYPE0] && xpin0_fall) |=> tctrl[B_XDET0]) // [RULE4]
      else $error("edge detect flag missing");
   a_gate_block: assert property (@(posedge core_clk) disable iff (rst)
      (cfg0[B_GATE] && !xpin0_lvl) |-> !inc0) // [RULE5]
      else $error("gated timer counted with pin low");
   a_ungated_run: assert property (@(posedge core_clk) disable iff (rst)
      (!cfg0[B_GATE] && tctrl[B_RUN0] && !cfg0[B_CT] && tick0) |-> inc0) // [RULE6]
      else $error("ungated timer missed a tick");
   a_reload_value: assert property (@(posedge core_clk) disable iff (rst)
      (cfg0[1:0] == MODE_AR && inc0 && t0_low == 8'hff && !wr_t0_low && !wr_t0_high)
      |=> (t0_low == t0_high) && $stable(t0_high)) // [RULE10]
      else $error("auto reload wrong");
   a_t1_split_stop: assert property (@(posedge core_clk) disable iff (rst)
      (cfg1[1:0] == MODE_SPLIT && !wr_t1_low && !wr_t1_high)
      |=> $stable({t1_high, t1_low})) // [RULE12]
      else $error("timer 1 moved in mode 3");
   a_write_wins: assert property (@(posedge core_clk) disable iff (rst)
      wr_t1_low |=> t1_low == $past(reg_wdata)) // [RULE16]
      else $error("byte write lost");
endmodule : dtc_timer

// >>> dtc_pkg.sv
// Constants and register map for the dual timer/counter block.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
//
// Notes on behaviour
// RULE1: overflow flag sets on overflow, clears on vector ack; software may write it.
// RULE2: run bit written by software; timer counts only while run set.
// RULE3: detect flag sets on edge or level; edge mode clears on ack, level follows pin.
// RULE4: type bit picks falling edge (1) or low level (0) detection.
// RULE5: with pin qualify set, count only while interrupt pin high and run set.
// RULE6: with pin qualify clear, count whenever run is set.
// RULE7: source select clear counts divided clock, set counts count-pin falling edges.
// RULE8: mode 00 is 8-bit counter behind a 5-bit prescaler in low byte.
// RULE9: mode 01 is a full 16-bit counter, no prescaler.
// RULE10: mode 10 low byte counts, reloads from unchanged high byte on overflow.
// RULE11: timer 0 mode 3 splits; high byte counts under timer 1 controls.
// RULE12: timer 1 in mode 3 stops and holds its value.
// RULE13: divide select 1 gives clock over 4, 0 gives clock over 12.
// RULE14: timer control register sits at address 88h.
// RULE15: mode register: timer 1 fields in upper nibble, timer 0 in lower.
// RULE16: counter bytes are always readable and writable; writes replace count.
package dtc_pkg;
   localparam logic [7:0] ADDR_TCTRL = 8'h88;
   localparam logic [7:0] ADDR_TMODE = 8'h89;
   localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
   localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
   localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_CKDIV = 8'h8e;
   localparam logic [7:0] ADDR_ISTAT = 8'hf0;
   localparam logic [7:0] ADDR_IMASK = 8'hf1;
   // Timer control bit positions
   localparam int B_OVF1 = 7;
   localparam int B_RUN1 = 6;
   localparam int B_OVF0 = 5;
   localparam int B_RUN0 = 4;
   localparam int B_XDET1 = 3;
   localparam int B_XTYPE1 = 2;
   localparam int B_XDET0 = 1;
   localparam int B_XTYPE0 = 0;
   // Mode nibble positions
   localparam int B_GATE = 3;
   localparam int B_CT = 2;
   localparam int B_MH = 1;
   localparam int B_ML = 0;
   // Clock divide select positions
   localparam int B_FAST1 = 4;
   localparam int B_FAST0 = 3;
   localparam logic [7:0] CKDIV_RESET = 8'h01;
   // Divider ratios, prescaler limit and mode codes
   localparam logic [3:0] DIV_FAST = 4'h4;
   localparam logic [3:0] DIV_SLOW = 4'hc;
   localparam logic [4:0] PRESC_MAX = 5'h1f;
   localparam logic [1:0] MODE_13 = 2'h0;
   localparam logic [1:0] MODE_16 = 2'h1;
   localparam logic [1:0] MODE_AR = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // Interrupt status bits: overflow 0, overflow 1, ext 0, ext 1
   localparam int NUM_IRQ = 4;
endpackage : dtc_pkg

// >>> dtc_tick.sv
// Divided clock tick generator for one timer.
// Assumes core_clk and synchronous rst; divide select from a register.
`timescale 1ns/1ps
module dtc_tick
   import dtc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic fast_sel,
   // Output
   output logic tick
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [3:0] limit;

   ////////////////////////////////////////////////////////////////////
   // Divide by 4 or 12
   always_comb begin
      limit = fast_sel ? DIV_FAST : DIV_SLOW; // [RULE13]
      if (cnt >= limit - 4'h1) begin
         next_cnt = 4'h0;
      end else begin
         next_cnt = cnt + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt <= 4'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign tick = (cnt == limit - 4'h1);

   a_tick_spacing: assert property (@(posedge core_clk) disable iff (rst)
      (tick && $stable(fast_sel) && fast_sel) |=> !tick [*3]) // [RULE13]
      else $error("fast tick spaced wrong");
endmodule : dtc_tick

// >>> dual_timer_counter_with_ext_int_tb.sv
// Self-checking bench for the dual timer/counter with external interrupt detection.
// Assumes dtc_pkg and dtc_timer are compiled first; the bench drives every port.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module dual_timer_counter_with_ext_int_tb;
   import dtc_pkg::*;
   logic core_clk;
   logic rst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_wr;
   logic reg_rd;
   logic [1:0] ext_pin;
   logic [1:0] cnt_pin;
   logic [3:0] ack;
   logic timer0_irq;
   logic timer1_irq;
   logic ext_external_interrupt_pin_0_irq;
   logic ext_external_interrupt_pin_1_irq;
   logic irq;
   logic [1:0] ext_irq;
   int errors;
   int check_count;
   logic [7:0] d;
   logic [7:0] d1;
   logic [7:0] r;
   int n;

   assign ext_irq = {ext_external_interrupt_pin_1_irq, ext_external_interrupt_pin_0_irq};

   dtc_timer uut (
      .core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .external_interrupt_pin_0(ext_pin[0]), .external_interrupt_pin_1(ext_pin[1]),
      .count_pin_0(cnt_pin[0]), .count_pin_1(cnt_pin[1]),
      .timer0_vector_ack(ack[0]), .timer1_vector_ack(ack[1]),
      .ext_external_interrupt_pin_0_vector_ack(ack[2]), .ext_external_interrupt_pin_1_vector_ack(ack[3]),
      .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
      .ext_external_interrupt_pin_0_irq(ext_external_interrupt_pin_0_irq), .ext_external_interrupt_pin_1_irq(ext_external_interrupt_pin_1_irq), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Hang guard
   initial begin
      repeat (50000) @(posedge core_clk);
      errors++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register port cycles, two clocks each so strobes never re-assert in one step
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge core_clk);
   endtask : rd

   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      `CHK(nm, e, v)
   endtask : chk_rd

   task automatic ack_pulse(input int i);
      ack[i] <= 1'b1;
      @(posedge core_clk);
      ack[i] <= 1'b0;
      @(posedge core_clk);
   endtask : ack_pulse

   // Expected tick count for a span of core clocks
   function automatic int ticks(input int span, input int dv);
      return span / dv;
   endfunction : ticks

   function automatic logic in_rng(input logic [7:0] v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_rng

   // Timer 0 mode 1 run for 242 clocks at a given divide
   task automatic rate(input logic [7:0] ck, input int dv);
      wr(ADDR_CKDIV, ck);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_T0_HIGH, 8'h00);
      wr(ADDR_TCTRL, 8'h10);
      cyc(240);
      wr(ADDR_TCTRL, 8'h00);
      rd(ADDR_T0_LOW, d);
      `CHK("rate", 1'b1, in_rng(d, ticks(242, dv) - 2, ticks(242, dv) + 2))
   endtask : rate

   task automatic give_verdict();
      if (errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      ext_pin = 2'b11;
      cnt_pin = 2'b11;
      ack = 4'h0;
      errors = 0;
      check_count = 0;
      void'($urandom(32'ha179));
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // Reset values and map
      for (int a = 8'h88; a <= 8'h8e; a++) begin
         chk_rd("reset", 8'(a), (a == 8'h8e) ? CKDIV_RESET : 8'h00);
      end
      wr(8'h87, 8'h55);
      chk_rd("unmapped", 8'h87, 8'hff);
      // Random read/write of byte and mode registers
      for (int a = 8'h89; a <= 8'h8d; a++) begin
         r = 8'($urandom);
         wr(8'(a), r);
         chk_rd("rw", 8'(a), r);
      end
      // Divide by 12 then by 4
      wr(ADDR_TMODE, 8'h01);
      rate(8'h01, 12);
      rate(8'h09, 4);
      // Overflow, masking, acknowledge and software access of the flag
      wr(ADDR_T0_LOW, 8'hfe);
      wr(ADDR_T0_HIGH, 8'hff);
      wr(ADDR_TCTRL, 8'h10);
      cyc(20);
      chk_rd("ovf0", ADDR_TCTRL, 8'h30);
      wr(ADDR_TCTRL, 8'h20);
      #1 `CHK("t0irq", 1'b1, timer0_irq)
      `CHK("masked", 1'b0, irq)
      @(posedge core_clk);
      wr(ADDR_IMASK, 8'h01);
      #1 `CHK("irq", 1'b1, irq)
      @(posedge core_clk);
      ack_pulse(0);
      #1 `CHK("t0ack", 1'b0, timer0_irq)
      @(posedge core_clk);
      wr(ADDR_ISTAT, 8'h01);
      #1 `CHK("irqclr", 1'b0, irq)
      @(posedge core_clk);
      wr(ADDR_TCTRL, 8'h20);
      chk_rd("swset", ADDR_TCTRL, 8'h20);
      wr(ADDR_TCTRL, 8'h00);
      // Mode 2 reload on timer 1
      wr(ADDR_TMODE, 8'h20);
      wr(ADDR_CKDIV, 8'h19);
      r = 8'($urandom_range(8'hf0, 0));
      wr(ADDR_T1_HIGH, r);
      wr(ADDR_T1_LOW, 8'hfe);
      wr(ADDR_TCTRL, 8'h40);
      cyc(12);
      chk_rd("ovf1", ADDR_TCTRL, 8'hc0);
      #1 `CHK("t1irq", 1'b1, timer1_irq)
      wr(ADDR_TCTRL, 8'h00);
      rd(ADDR_T1_LOW, d);
      `CHK("reload", 1'b1, in_rng(d, r, r + 3))
      chk_rd("hold1", ADDR_T1_HIGH, r);
      // Mode 0 prescaler preset to 1eh carries into the high byte after 2 counts
      wr(ADDR_TMODE, 8'h00);
      wr(ADDR_T0_HIGH, 8'h00);
      wr(ADDR_T0_LOW, 8'h1e);
      wr(ADDR_TCTRL, 8'h10);
      cyc(14);
      wr(ADDR_TCTRL, 8'h00);
      chk_rd("presc", ADDR_T0_HIGH, 8'h01);
      // Split mode: high byte of timer 0 runs under timer 1 run bit
      wr(ADDR_TMODE, 8'h03);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_T0_HIGH, 8'h00);
      wr(ADDR_TCTRL, 8'h40);
      cyc(120);
      wr(ADDR_TCTRL, 8'h00);
      rd(ADDR_T0_HIGH, d);
      `CHK("split", 1'b1, in_rng(d, ticks(122, 4) - 2, ticks(122, 4) + 2))
      chk_rd("splitlo", ADDR_T0_LOW, 8'h00);
      // Timer 1 in mode 3 holds
      wr(ADDR_TMODE, 8'h30);
      wr(ADDR_T1_LOW, 8'h05);
      wr(ADDR_TCTRL, 8'h40);
      cyc(60);
      wr(ADDR_TCTRL, 8'h00);
      chk_rd("t1hold", ADDR_T1_LOW, 8'h05);
      // Pin qualification; let the low pin pass the synchroniser before run
      wr(ADDR_TMODE, 8'h09);
      wr(ADDR_T0_LOW, 8'h00);
      ext_pin[0] <= 1'b0;
      cyc(3);
      wr(ADDR_TCTRL, 8'h10);
      cyc(40);
      chk_rd("gatelo", ADDR_T0_LOW, 8'h00);
      ext_pin[0] <= 1'b1;
      cyc(40);
      rd(ADDR_T0_LOW, d1);
      `CHK("gatehi", 1'b1, in_rng(d1, ticks(40, 4) - 3, ticks(40, 4) + 3))
      wr(ADDR_TMODE, 8'h01);
      ext_pin[0] <= 1'b0;
      cyc(40);
      wr(ADDR_TCTRL, 8'h00);
      rd(ADDR_T0_LOW, d);
      `CHK("nogate", 1'b1, d > d1 + 5)
      cyc(20);
      chk_rd("stopped", ADDR_T0_LOW, d);
      ext_pin[0] <= 1'b1;
      // Counter mode on count pin falling edges
      wr(ADDR_TMODE, 8'h05);
      wr(ADDR_T0_LOW, 8'h00);
      wr(ADDR_TCTRL, 8'h10);
      n = $urandom_range(12, 1);
      repeat (n) begin
         cnt_pin[0] <= 1'b0;
         cyc(4);
         cnt_pin[0] <= 1'b1;
         cyc(4);
      end
      cyc(6);
      chk_rd("count", ADDR_T0_LOW, 8'(n));
      wr(ADDR_TCTRL, 8'h00);
      // External inputs: falling edge then low level
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_TCTRL, 8'(1 << (2 * i)));
         ext_pin[i] <= 1'b0;
         cyc(8);
         ext_pin[i] <= 1'b1;
         cyc(8);
         rd(ADDR_TCTRL, d);
         `CHK("edge", 1'b1, d[2 * i + 1])
         `CHK("extirq", 1'b1, ext_irq[i])
         ack_pulse(2 + i);
         rd(ADDR_TCTRL, d);
         `CHK("edgeack", 1'b0, d[2 * i + 1])
         wr(ADDR_TCTRL, 8'h00);
         ext_pin[i] <= 1'b0;
         cyc(8);
         rd(ADDR_TCTRL, d);
         `CHK("level", 1'b1, d[2 * i + 1])
         ext_pin[i] <= 1'b1;
         cyc(8);
         rd(ADDR_TCTRL, d);
         `CHK("follow", 1'b0, d[2 * i + 1])
      end
      give_verdict();
   end
endmodule : dual_timer_counter_with_ext_int_tb
